// *** core/dxe_access_unit.sv ***
// extension access gating, exception decision, control word and its interlock
//
// Local design decisions: the plain strobed port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - config bit 10 shows base extension present
// - config bit 11 shows revision two present
// - revision two never without base presence
// - presence flags constant, writes ignored
// - software reads all three presence flags
// - unsupported extension instruction takes reserved instruction
// - status bit 24 gates extension and accumulators
// - disabled access raises state disabled, code 26
// - base only: disabled, else rev2 reserved
// - none present reserved; both present enable-gated
// - same checks for any extension state access
// - stall on control word data dependencies
// - full control word write and read
// - position field written and read as listed
// - carry, extract fail, insert size fields
// - compare condition written by compares, read by select
// - extension instructions never raise arithmetic overflow
// - non-arithmetic exceptions such as address still raised
// - overflow flags sticky, cleared by full write
module dxe_access_unit
    import dxe_pkg::*;
#(
    parameter bit BASE_PRESENT = 1'b1,   // base extension built in
    parameter bit REV2_PRESENT = 1'b1,   // second revision built in
    parameter bit REV3_PRESENT = 1'b0    // third revision built in
) (
    input  wire logic              core_clk,   // core clock
    input  wire logic              rst,        // synchronous reset, high
    input  wire logic [7:0]        reg_addr,   // register byte address
    input  wire logic [31:0]       reg_wdata,  // register write data
    input  wire logic              reg_wr,     // register write strobe
    input  wire logic              reg_rd,     // register read strobe
    output logic      [31:0]       reg_rdata,  // read data, cycle after strobe
    input  wire dxe_decode_type    dec,        // decode stage request
    input  wire dxe_writeback_type wb,         // control word update
    output dxe_exc_type            exc,        // exception decision
    output logic                   stall,      // hold decode
    output logic                   issue,      // decode instruction proceeds
    output logic      [31:0]       control_word // current control word to datapath
);

    // refuse a presence combination the hardware must never produce
    generate
        if (REV2_PRESENT && !BASE_PRESENT) begin : g_bad_rev2
            $error("revision two present requires base present");
        end
        if (REV3_PRESENT && !REV2_PRESENT) begin : g_bad_rev3
            $error("revision three present requires revision two present");
        end
    endgenerate

    // all state of the block
    typedef struct packed {
        logic [31:0] proc_status;   // processor status image
        logic [31:0] cword;         // extension control word, storable bits
        logic [6:0]  pending;       // fields with a write in flight
        logic [4:0]  last_code;     // code of last reserved or disabled exception
        logic [31:0] rdata;         // registered read data
    } dxe_state_type;

    dxe_state_type st;       // registered state
    dxe_state_type next_st;  // next state

    // presence flags are wired constants, never stored
    logic [31:0] feature_cfg;    // feature_presence_config read image
    logic        base_present;   // ext_base_present_flag
    logic        rev2_present;   // ext_rev2_present_flag
    logic        rev3_present;   // ext_rev3_present_flag
    logic        access_enable;  // ext_access_enable
    logic        gated;          // decode instruction is subject to the checks
    logic        supported;      // presence flags cover the instruction
    logic        hazard;         // dependency on an in-flight write
    logic [31:0] cword_view;     // control word as read, presence bit merged
    logic [31:0] field_mask;     // bit mask of fields replaced by writeback

    assign base_present  = BASE_PRESENT;
    assign rev2_present  = REV2_PRESENT;
    assign rev3_present  = REV3_PRESENT;
    assign access_enable = st.proc_status[ACCESS_ENABLE_BIT];

    // other config bits read zero; the flags cannot be written
    always_comb begin
        feature_cfg = 32'h0000_0000;
        feature_cfg[BASE_PRESENT_BIT] = base_present;
        feature_cfg[REV2_PRESENT_BIT] = rev2_present;
    end

    // presence bit of revision three shows inside the control word
    always_comb begin
        cword_view = st.cword;
        cword_view[REV3_PRESENT_BIT] = rev3_present;
    end

    assign control_word = cword_view;

    // expand a field mask into the control word bits it covers
    function automatic logic [31:0] fields_to_bits(input logic [6:0] f);
        logic [31:0] m;
        m = 32'h0000_0000;
        if (f[FLD_POS])    m[POS_MSB:POS_LSB]       = 6'h3f;
        if (f[FLD_SCOUNT]) m[SCOUNT_MSB:SCOUNT_LSB] = 6'h3f;
        if (f[FLD_CARRY])  m[CARRY_BIT]             = 1'b1;
        if (f[FLD_EFI])    m[EFI_BIT]               = 1'b1;
        if (f[FLD_OUFLAG]) m[OUF_MSB:OUF_LSB]       = 8'hff;
        if (f[FLD_CCOND])  m[CCOND_MSB:CCOND_LSB]   = 4'hf;
        // other bits are 31:29, 15 and 6; carry and the presence bit stay out
        if (f[FLD_OTHER])  m = m | 32'he000_8040;
        m[REV3_PRESENT_BIT] = 1'b0;
        return m;
    endfunction

    // does the decode instruction fall under the access checks
    always_comb begin
        case (dec.iclass)
            CLS_BASE, CLS_REV2, CLS_REV3: gated = dec.valid;
            CLS_ACCMV: gated = dec.valid & dec.acc_upper;
            CLS_OTHER: gated = dec.valid;
            default:   gated = 1'b0;
        endcase
    end

    // which implementation levels cover the instruction
    always_comb begin
        case (dec.iclass)
            CLS_BASE, CLS_ACCMV, CLS_OTHER: supported = base_present;
            CLS_REV2: supported = base_present & rev2_present;
            CLS_REV3: supported = base_present & rev2_present & rev3_present;
            default:  supported = 1'b1;
        endcase
    end

    // decision formed straight from decode, so it precedes any state update
    always_comb begin
        exc = '0;
        if (gated && !base_present) begin
            // nothing present gives reserved whatever the enable
            exc.reserved_instr = 1'b1;
            exc.exc_code       = EXC_CODE_RESERVED;
        end else if (gated && !access_enable) begin
            // any level present: disabled wins over a missing revision
            exc.state_disabled = 1'b1;
            exc.exc_code       = EXC_CODE_DISABLED;
        end else if (gated && !supported) begin
            // enabled, but this level is not built
            exc.reserved_instr = 1'b1;
            exc.exc_code       = EXC_CODE_RESERVED;
        end else if (dec.valid && dec.addr_fault) begin
            // address faults stay architectural for extension loads
            exc.addr_exc = 1'b1;
        end else if (dec.valid && dec.ovf_request && dec.iclass == CLS_NONE) begin
            // extension classes swallow overflow; only flags record it
            exc.arith_ovf = 1'b1;
        end
    end

    // read after write and write after write on any in-flight field
    // one write per field may be in flight; a second waits, which costs some
    // throughput but keeps the scoreboard a single bit per field
    assign hazard = dec.valid & (|((dec.rd_fields | dec.wr_fields) & st.pending));
    assign stall  = hazard & ~(exc.reserved_instr | exc.state_disabled);
    assign issue  = dec.valid & ~stall & ~(|{exc.reserved_instr, exc.state_disabled,
                                             exc.addr_exc, exc.arith_ovf});

    assign field_mask = fields_to_bits(wb.fields);

    // next state
    always_comb begin
        next_st = st;
        next_st.rdata = 32'h0000_0000;

        // retired field updates: full write replaces all bits
        // pos carry, extract fail, insert size ccond
        if (wb.valid) begin
            next_st.cword   = (st.cword & ~field_mask) | (wb.wdata & field_mask);
            next_st.pending = st.pending & ~wb.fields;
            // sticky overflow bits set on every retired update, full write included
            next_st.cword[OUF_MSB:OUF_LSB] = next_st.cword[OUF_MSB:OUF_LSB] | wb.ouflag_set;
        end

        // new write in flight; set beats a same-cycle clear
        if (issue) begin
            next_st.pending = next_st.pending | dec.wr_fields;
        end

        // remember code of the raised exception
        if (exc.reserved_instr || exc.state_disabled) begin
            next_st.last_code = exc.exc_code;
        end

        // software register writes
        if (reg_wr) begin
            case (reg_addr)
                ADDR_PROC_STATUS: next_st.proc_status = reg_wdata;
                ADDR_CONTROL_WORD: begin
                    // direct software write acts as full replacement
                    next_st.cword = reg_wdata;
                    next_st.cword[OUF_MSB:OUF_LSB] = reg_wdata[OUF_MSB:OUF_LSB]
                                                   | (wb.valid ? wb.ouflag_set : 8'h00);
                end
                default: ;                                   // config is read only
            endcase
        end
        next_st.cword[REV3_PRESENT_BIT] = 1'b0;             // constant, never stored

        // software register reads, data in the next cycle
        if (reg_rd) begin
            case (reg_addr)
                ADDR_FEATURE_CFG:  next_st.rdata = feature_cfg;
                ADDR_PROC_STATUS:  next_st.rdata = st.proc_status;
                ADDR_CONTROL_WORD: next_st.rdata = cword_view;
                ADDR_EXC_STATUS:   next_st.rdata = {20'h00000, st.pending, st.last_code};
                default:           next_st.rdata = 32'h0000_0000;
            endcase
        end

        if (rst) begin
            next_st.proc_status = PROC_STATUS_RESET;
            next_st.cword       = CONTROL_WORD_RESET;
            next_st.pending     = 7'h00;
            next_st.last_code   = EXC_CODE_NONE;
            next_st.rdata       = 32'h0000_0000;
        end
    end

    // state register
    always_ff @(posedge core_clk) begin
        st <= next_st;
    end

    assign reg_rdata = st.rdata;

endmodule : dxe_access_unit
`default_nettype wire

// *** core/dxe_pkg.sv ***
// constants and carrier types for the extension access exception unit
package dxe_pkg;

    // register port word offsets (byte addresses, one word each)
    localparam logic [7:0] ADDR_FEATURE_CFG  = 8'h00;  // feature_presence_config
    localparam logic [7:0] ADDR_PROC_STATUS  = 8'h04;  // processor_status
    localparam logic [7:0] ADDR_CONTROL_WORD = 8'h08;  // ext_control_word
    localparam logic [7:0] ADDR_EXC_STATUS   = 8'h0c;  // last reserved or disabled code and pending writes

    // presence flag positions
    localparam int BASE_PRESENT_BIT = 10;              // in feature_presence_config
    localparam int REV2_PRESENT_BIT = 11;              // in feature_presence_config
    localparam int REV3_PRESENT_BIT = 28;              // in ext_control_word

    // access enable position in processor_status
    localparam int ACCESS_ENABLE_BIT = 24;

    // control word field layout
    localparam int POS_LSB    = 0;
    localparam int POS_MSB    = 5;
    localparam int SCOUNT_LSB = 7;
    localparam int SCOUNT_MSB = 12;
    localparam int CARRY_BIT  = 13;
    localparam int EFI_BIT    = 14;
    localparam int OUF_LSB    = 16;
    localparam int OUF_MSB    = 23;
    localparam int CCOND_LSB  = 24;
    localparam int CCOND_MSB  = 27;

    // reset values
    localparam logic [31:0] PROC_STATUS_RESET  = 32'h0000_0000;
    localparam logic [31:0] CONTROL_WORD_RESET = 32'h0000_0000;

    // exception codes
    localparam logic [4:0] EXC_CODE_NONE     = 5'h00;
    localparam logic [4:0] EXC_CODE_RESERVED = 5'h0a;  // reserved instruction
    localparam logic [4:0] EXC_CODE_DISABLED = 5'h1a;  // extension state disabled, 26

    // field mask bit indices
    localparam int FLD_POS    = 0;
    localparam int FLD_SCOUNT = 1;
    localparam int FLD_CARRY  = 2;
    localparam int FLD_EFI    = 3;
    localparam int FLD_OUFLAG = 4;
    localparam int FLD_CCOND  = 5;
    localparam int FLD_OTHER  = 6;                     // remaining bits, full read/write only
    localparam int NUM_FIELDS = 7;
    localparam logic [6:0] FLD_ALL = 7'h7f;

    // instruction classes presented by decode
    typedef enum logic [2:0] {
        CLS_NONE   = 3'h0,   // not an extension-related instruction
        CLS_BASE   = 3'h1,   // base extension instruction
        CLS_REV2   = 3'h2,   // second revision instruction
        CLS_REV3   = 3'h3,   // third revision instruction
        CLS_ACCMV  = 3'h4,   // accumulator move to/from
        CLS_OTHER  = 3'h5    // any other instruction touching extension state
    } dxe_class_type;

    // decode stage request
    typedef struct packed {
        logic          valid;        // an instruction is in decode
        dxe_class_type iclass;       // its class
        logic          acc_upper;    // it names accumulator one, two or three
        logic [6:0]    rd_fields;    // control word fields it reads
        logic [6:0]    wr_fields;    // control word fields it will write
        logic          ovf_request;  // datapath would flag arithmetic overflow
        logic          addr_fault;   // its memory address faults
    } dxe_decode_type;

    // writeback of control word fields
    typedef struct packed {
        logic        valid;          // an update retires this cycle
        logic [6:0]  fields;         // fields replaced from wdata
        logic [31:0] wdata;          // new field values, in place
        logic [7:0]  ouflag_set;     // sticky overflow bits to set
    } dxe_writeback_type;

    // exception decision to the pipeline
    typedef struct packed {
        logic       reserved_instr;  // reserved instruction exception
        logic       state_disabled;  // state disabled exception
        logic       arith_ovf;       // arithmetic overflow exception
        logic       addr_exc;        // address exception
        logic [4:0] exc_code;        // cause register code
    } dxe_exc_type;

endpackage : dxe_pkg

// *** tb/dxe_pipe_model.sv ***
// pipeline partner: forwards decode requests and retires their field writes
`timescale 1ns/1ns
`default_nettype none
module dxe_pipe_model
    import dxe_pkg::*;
#(
    parameter logic [3:0]  WB_DELAY = 4'h3,          // cycles from issue to retire
    parameter logic [31:0] WB_WDATA = 32'h0000_2015, // retired field values
    parameter logic [7:0]  WB_OUF   = 8'h21          // overflow bits raised on retire
) (
    input  wire logic           core_clk, // clock
    input  wire logic           rst,      // reset
    input  wire dxe_decode_type req,      // request from the bench
    input  wire logic           issue,    // decode proceeds
    output dxe_decode_type      dec,      // request into decode
    output dxe_writeback_type   wb        // retiring update
);
    logic [3:0] cnt; // cycles left until retire
    logic [6:0] fld; // fields the retiring op writes
    assign dec = req;
    // idle cycles show the inverse so a stale update never looks valid
    assign wb = (cnt == 4'h1) ? {1'b1, fld, WB_WDATA, WB_OUF} : {1'b0, ~fld, ~WB_WDATA, ~WB_OUF};
    // one op in flight: the bench waits for retire before the next writer
    always @(posedge core_clk) begin
        if (rst) begin
            cnt <= 4'h0;
            fld <= 7'h00;
        end else if (issue && req.valid && req.wr_fields != 7'h00) begin
            cnt <= WB_DELAY;
            fld <= req.wr_fields;
        end else if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
        end
    end
endmodule // dxe_pipe_model
`default_nettype wire

// *** tb/dxe_access_props.sv ***
// assertion checker for the extension access unit
`timescale 1ns/1ns
`default_nettype none
module dxe_access_props
    import dxe_pkg::*;
#(
    parameter bit BASE_PRESENT = 1'b1, // base built in
    parameter bit REV2_PRESENT = 1'b1, // revision two built in
    parameter bit REV3_PRESENT = 1'b0  // revision three built in
) (
    input wire logic              core_clk,    // clock
    input wire logic              rst,         // reset
    input wire logic [7:0]        reg_addr,    // address
    input wire logic [31:0]       reg_wdata,   // write data
    input wire logic              reg_wr,      // write strobe
    input wire logic              reg_rd,      // read strobe
    input wire logic [31:0]       reg_rdata,   // read data
    input wire dxe_decode_type    dec,         // decode request
    input wire dxe_writeback_type wb,          // field update
    input wire dxe_exc_type       exc,         // decision
    input wire logic              stall,       // hold decode
    input wire logic              issue,       // proceeds
    input wire logic [31:0]       control_word // control word
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    logic       mx;   // shadow of the access enable
    logic [6:0] pend; // shadow of fields awaiting retire
    // shadows built from port traffic only
    always_ff @(posedge core_clk) begin
        if (rst) begin
            mx   <= 1'b0;
            pend <= 7'h00;
        end else begin
            if (reg_wr && reg_addr == ADDR_PROC_STATUS) mx <= reg_wdata[ACCESS_ENABLE_BIT];
            pend <= (pend & ~(wb.valid ? wb.fields : 7'h00)) | (issue && dec.valid ? dec.wr_fields : 7'h00);
        end
    end
    sequence s_cfg_read;
        reg_rd && reg_addr == ADDR_FEATURE_CFG;
    endsequence
    sequence s_cw_write;
        reg_wr && reg_addr == ADDR_CONTROL_WORD && !wb.valid;
    endsequence
    property p_cfg; s_cfg_read |=> reg_rdata[11:10] == {REV2_PRESENT, BASE_PRESENT}; endproperty
    a_cfg: assert property (p_cfg) else $error("presence flags read wrong");
    property p_dis;
        dec.valid && dec.iclass inside {CLS_BASE, CLS_REV2, CLS_REV3, CLS_OTHER} && BASE_PRESENT && !mx
        |-> exc.state_disabled && exc.exc_code == EXC_CODE_DISABLED;
    endproperty
    a_dis: assert property (p_dis) else $error("disabled access not raised");
    property p_rsv;
        dec.valid && dec.iclass == CLS_REV2 && !REV2_PRESENT && mx |-> exc.reserved_instr && exc.exc_code == EXC_CODE_RESERVED;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved instruction not raised");
    property p_acc; dec.valid && dec.iclass == CLS_ACCMV && !dec.acc_upper |-> !exc.state_disabled; endproperty
    a_acc: assert property (p_acc) else $error("lower accumulator move gated");
    property p_novf; dec.valid && dec.iclass != CLS_NONE |-> !exc.arith_ovf; endproperty
    a_novf: assert property (p_novf) else $error("overflow exception from extension");
    property p_addr;
        dec.valid && dec.addr_fault && dec.iclass == CLS_BASE && BASE_PRESENT && mx |-> exc.addr_exc;
    endproperty
    a_addr: assert property (p_addr) else $error("address exception lost");
    property p_stall;
        dec.valid && ((dec.rd_fields | dec.wr_fields) & pend) != 7'h00 && !exc.reserved_instr && !exc.state_disabled
        |-> stall && !issue;
    endproperty
    a_stall: assert property (p_stall) else $error("dependency not stalled");
    property p_full; s_cw_write |=> control_word == (($past(reg_wdata) & 32'hefff_ffff) | {3'h0, REV3_PRESENT, 28'h0}); endproperty
    a_full: assert property (p_full) else $error("control word write not full");
    property p_sticky;
        wb.valid && !(reg_wr && reg_addr == ADDR_CONTROL_WORD) |=> (control_word[23:16] & $past(wb.ouflag_set)) == $past(wb.ouflag_set);
    endproperty
    a_sticky: assert property (p_sticky) else $error("overflow flags lost");
endmodule // dxe_access_props
bind dxe_access_unit dxe_access_props #(.BASE_PRESENT(BASE_PRESENT), .REV2_PRESENT(REV2_PRESENT),
    .REV3_PRESENT(REV3_PRESENT)) u_props (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dec(dec), .wb(wb),
    .exc(exc), .stall(stall), .issue(issue), .control_word(control_word));
`default_nettype wire

// *** tb/dxe_access_unit_tb.sv ***
// self-checking bench for the extension access unit, base extension only
`timescale 1ns/1ns
`default_nettype none
module dxe_access_unit_tb;
    import dxe_pkg::*;
    logic core_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, stall, issue; // clock, strobes, flags
    logic [7:0]  reg_addr = 8'h00;  // register address
    logic [31:0] reg_wdata = '0, reg_rdata, control_word; // register data
    dxe_decode_type req = '0, dec;  // request and forwarded decode
    dxe_writeback_type wb;          // retiring update
    dxe_exc_type exc;               // decision
    int errors = 0, n_compared = 0; // tallies
    always #5 core_clk = ~core_clk;
    dxe_access_unit #(.BASE_PRESENT(1'b1), .REV2_PRESENT(1'b0), .REV3_PRESENT(1'b0)) uut (.core_clk(core_clk),
        .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .dec(dec), .wb(wb), .exc(exc), .stall(stall), .issue(issue), .control_word(control_word));
    dxe_pipe_model u_pipe (.core_clk(core_clk), .rst(rst), .req(req), .issue(issue), .dec(dec), .wb(wb));
    task automatic tally_and_finish();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic chk_exc(input string nm, input dxe_exc_type exp);
        n_compared++;
        if (exc !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, exc);
        end
    endtask
    function automatic dxe_exc_type mk(input logic r, input logic d, input logic a);
        mk = '{r, d, 1'b0, a, r ? EXC_CODE_RESERVED : d ? EXC_CODE_DISABLED : EXC_CODE_NONE};
    endfunction
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic reg_read(input logic [7:0] a, input logic [31:0] exp, input string nm);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 chk(nm, exp, reg_rdata);
    endtask
    // hold the request until decode lets it go, bounded
    task automatic send(input dxe_class_type cl, input logic [6:0] rd, input logic [6:0] wr, input logic st);
        int k;
        @(posedge core_clk);
        req <= '{1'b1, cl, 1'b0, rd, wr, 1'b0, 1'b0};
        #1 chk("stall", {31'h0, st}, {31'h0, stall});
        // look at issue while it is settled, then let the next edge take it
        for (k = 0; k < 20; k++) begin
            if (issue === 1'b1) break;
            @(posedge core_clk);
            #1;
        end
        if (k == 20) begin
            errors++;
            $display("ERROR issue expected 1 seen timeout");
            tally_and_finish();
        end
        @(posedge core_clk);
        req <= '0;
    endtask
    task automatic t_regs();
        reg_read(ADDR_FEATURE_CFG, 32'h0000_0400, "config");
        @(posedge core_clk);
        #1 chk("rdata idle", 32'h0000_0000, reg_rdata);
        reg_write(ADDR_FEATURE_CFG, 32'hffff_ffff);
        reg_read(ADDR_FEATURE_CFG, 32'h0000_0400, "config kept");
        reg_read(ADDR_PROC_STATUS, PROC_STATUS_RESET, "status");
        reg_read(ADDR_CONTROL_WORD, CONTROL_WORD_RESET, "cword reset");
        reg_read(8'h10, 32'h0000_0000, "unmapped");
    endtask
    // every extension class against both enable values; lower accumulator move is never gated
    task automatic t_gate();
        dxe_class_type cl[5] = '{CLS_BASE, CLS_REV2, CLS_REV3, CLS_OTHER, CLS_ACCMV};
        logic up;
        for (int m = 0; m < 2; m++) begin
            reg_write(ADDR_PROC_STATUS, 32'(m) << ACCESS_ENABLE_BIT);
            for (int i = 0; i < 6; i++) begin
                up = (i < 5);
                @(posedge core_clk);
                req <= '{1'b1, cl[i > 4 ? 4 : i], up, 7'h00, 7'h00, 1'b1, 1'b0};
                #1 chk_exc("gate", mk(m == 1 && i inside {1, 2}, m == 0 && up, 1'b0));
            end
        end
        @(posedge core_clk);
        req <= '{1'b1, CLS_NONE, 1'b0, 7'h00, 7'h00, 1'b1, 1'b0};
        #1 chk_exc("ovf", '{1'b0, 1'b0, 1'b1, 1'b0, EXC_CODE_NONE});
        @(posedge core_clk);
        req <= '{1'b1, CLS_BASE, 1'b0, 7'h00, 7'h00, 1'b1, 1'b1};
        #1 chk_exc("fault", mk(1'b0, 1'b0, 1'b1));
        @(posedge core_clk);
        req <= '0;
        reg_read(ADDR_EXC_STATUS, {27'h0000000, EXC_CODE_RESERVED}, "last code");
    endtask
    // writer then dependent reader, twice; only the written field and the overflow flags may change
    task automatic t_stall();
        send(CLS_BASE, 7'h00, 7'h01, 1'b0);
        send(CLS_BASE, 7'h01, 7'h00, 1'b1);
        #1 chk("cword pos", 32'h0021_0015, control_word);
        send(CLS_BASE, 7'h00, 7'h04, 1'b0);
        send(CLS_BASE, 7'h04, 7'h00, 1'b1);
        #1 chk("cword carry", 32'h0021_2015, control_word);
    endtask
    task automatic t_cword();
        reg_write(ADDR_CONTROL_WORD, 32'hffff_ffff);
        reg_read(ADDR_CONTROL_WORD, 32'hefff_ffff, "cword all");
        reg_write(ADDR_CONTROL_WORD, 32'h0000_0000);
        reg_read(ADDR_CONTROL_WORD, 32'h0000_0000, "cword clear");
    endtask
    initial begin
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        t_regs();
        t_gate();
        t_stall();
        t_cword();
        tally_and_finish();
    end
endmodule // dxe_access_unit_tb
`default_nettype wire
